// ### ssr8_pkg.sv
/*
 * Shared constants and carrier types for the eight-stage shift-and-store register.
 * Assumes one system clock (CLK_I, 40 MHz) and host pins that are asynchronous to it.
 */
// Function
// - eight shift stages feed eight parallel outputs through a storage register; two cascade outs.
// - each shift clock rising edge advances the stages, serial input enters stage 0.
// - shift stages follow the shift clock; the storage register follows the store strobe.
// - on rising edge stage 6 moves to stage 7 and the fast cascade output.
// - fast cascade output shows stage 6 from before the rise; falling edges leave it.
// - slow cascade output takes the last stage on the next falling edge, half period later.
// - slow cascade output samples stage 7 from before the fall; rising edges leave it.
// - strobe high passes shift stages into storage; strobe low holds storage.
// - output enable high drives storage contents onto the parallel outputs.
// - output enable low releases the parallel outputs to high impedance.
// - output enable changes never alter shift or storage contents.
package ssr8_pkg;
    localparam int          STAGES       = 8;
    localparam int          FAST_TAP     = 6;     // stage copied to the fast cascade output
    localparam int          SLOW_TAP     = 7;     // stage copied to the slow cascade output
    localparam int          SYNC_DEPTH   = 3;
    localparam int          BUF_DEPTH    = 2;
    localparam int          CLK_FREQ_HZ  = 40_000_000;
    localparam logic [7:0]  SHIFT_RST    = 8'h00;
    localparam logic [7:0]  STORE_RST    = 8'h00;
    localparam logic [7:0]  OE_ALL       = 8'hFF;
    localparam logic [7:0]  OE_NONE      = 8'h00;
    localparam logic        CASCADE_RST  = 1'b0;

    // pins arriving from the host, one field per pin
    typedef struct packed {
        logic shift_clock;
        logic serial_data;
        logic store_strobe;
        logic output_enable;
    } ssr8_pins_t;
endpackage

// ### ssr8_buffer.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes a synchronous, active-high reset on the same clock as both sides.
 */
`timescale 1ns/1ps
module ssr8_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // checked at elaboration: the index and count logic needs two entries or more
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_params
        $error("buffer needs DEPTH >= 2 and WIDTH >= 1");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [IW-1:0]    wr_idx;
    logic [IW-1:0]    rd_idx;
    logic [IW:0]      count;

    function automatic logic [IW-1:0] bump(input logic [IW-1:0] idx);
        bump = (idx == IW'(DEPTH - 1)) ? '0 : idx + 1'b1;
    endfunction

    // honest full and empty from the occupancy count
    wire push = in_valid_i && in_ready_o;
    wire pop  = out_valid_o && out_ready_i;
    assign in_ready_o  = (count != (IW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_idx];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_idx] <= in_data_i;
        end
    end

    // pointers and count; simultaneous push and pop keep the count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count  <= '0;
        end else begin
            if (push) wr_idx <= bump(wr_idx);
            if (pop)  rd_idx <= bump(rd_idx);
            count <= count + (IW+1)'(push) - (IW+1)'(pop);
        end
    end
endmodule // ssr8_buffer

// ### ssr8_top.sv
/*
 * Eight-stage shift register with strobed storage register, tri-state parallel
 * port and two cascade outputs, oversampling the host pins on CLK_I.
 * Assumes the host holds each shift clock level for at least three CLK_I periods
 * and that the pad logic builds the tri-state wire from PARALLEL_OE_O.
 */
`timescale 1ns/1ps
module ssr8_top (
    input  wire logic       CLK_I,
    input  wire logic       SYS_RST_I,
    input  wire logic       SHIFT_CLOCK_I,
    input  wire logic       SERIAL_DATA_I,
    input  wire logic       STORE_STROBE_I,
    input  wire logic       OUTPUT_ENABLE_I,
    output logic [7:0]      PARALLEL_OUTPUTS_O,
    output logic [7:0]      PARALLEL_OE_O,
    output logic            CASCADE_OUT_FAST_O,
    output logic            CASCADE_OUT_SLOW_O,
    output logic [7:0]      STORE_DATA_O,
    output logic            STORE_VALID_O,
    input  wire logic       STORE_READY_I,
    output logic            STORE_ROOM_O
);
    localparam int N = ssr8_pkg::STAGES;

    // checked at elaboration: taps and filter are wired for these sizes only
    if (N != 8 || ssr8_pkg::SYNC_DEPTH != 3) begin : g_bad_params
        $error("logic is built for eight stages and a three-stage synchroniser");
    end

    ssr8_pkg::ssr8_pins_t pins_raw;
    ssr8_pkg::ssr8_pins_t sync1;
    ssr8_pkg::ssr8_pins_t sync2;
    ssr8_pkg::ssr8_pins_t sync3;
    ssr8_pkg::ssr8_pins_t filt;
    ssr8_pkg::ssr8_pins_t next_filt;
    logic [N-1:0]         shift_stages;
    logic [N-1:0]         storage;
    logic                 cascade_fast;
    logic                 cascade_slow;
    logic                 rise_pending;

    assign pins_raw = '{shift_clock: SHIFT_CLOCK_I, serial_data: SERIAL_DATA_I,
                        store_strobe: STORE_STROBE_I, output_enable: OUTPUT_ENABLE_I};

    // three-flop synchroniser; only sync2 reads sync1
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // a pin change counts once stages two and three agree
    assign next_filt = ssr8_pkg::ssr8_pins_t'((sync2 & sync3) | (filt & (sync2 ^ sync3)));

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            filt <= '0;
        end else begin
            filt <= next_filt;
        end
    end

    // edges of the filtered shift clock, one CLK_I cycle each
    wire rise_evt   = next_filt.shift_clock && !filt.shift_clock;
    wire fall_evt   = !next_filt.shift_clock && filt.shift_clock;
    wire strobe_lvl = filt.store_strobe;
    wire oe_lvl     = filt.output_enable;
    // data is taken from the same filtered sample set as the clock edge
    wire data_in    = next_filt.serial_data;
    wire strobe_end = filt.store_strobe && !next_filt.store_strobe;

    // shift stages move only on rising edges; oe plays no part here
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            shift_stages <= ssr8_pkg::SHIFT_RST;
        end else if (rise_evt) begin
            shift_stages <= {shift_stages[N-2:0], data_in};
        end
    end

    // storage is transparent while the strobe is high, a latch in clocked form
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            storage <= ssr8_pkg::STORE_RST;
        end else if (strobe_lvl) begin
            storage <= shift_stages;
        end
    end

    // cascade outputs: fast on rise, slow on fall, neither gated by oe
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            cascade_fast <= ssr8_pkg::CASCADE_RST;
            cascade_slow <= ssr8_pkg::CASCADE_RST;
        end else begin
            if (rise_evt) cascade_fast <= shift_stages[ssr8_pkg::FAST_TAP];
            if (fall_evt) cascade_slow <= shift_stages[ssr8_pkg::SLOW_TAP];
        end
    end

    // checker helper: a rise seen and no fall since
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            rise_pending <= 1'b0;
        end else if (rise_evt) begin
            rise_pending <= 1'b1;
        end else if (fall_evt) begin
            rise_pending <= 1'b0;
        end
    end

    // parallel port: data always from the storage flops, enable from oe
    assign PARALLEL_OUTPUTS_O = storage;
    assign PARALLEL_OE_O      = oe_lvl ? ssr8_pkg::OE_ALL : ssr8_pkg::OE_NONE;
    assign CASCADE_OUT_FAST_O = cascade_fast;
    assign CASCADE_OUT_SLOW_O = cascade_slow;

    // each finished strobe queues the published byte; a full buffer drops it,
    // so the host watches STORE_ROOM_O before strobing again
    ssr8_buffer #(
        .WIDTH (N),
        .DEPTH (ssr8_pkg::BUF_DEPTH)
    ) u_buffer (
        .clk_i       (CLK_I),
        .rst_i       (SYS_RST_I),
        .in_data_i   (storage),
        .in_valid_i  (strobe_end),
        .in_ready_o  (STORE_ROOM_O),
        .out_data_o  (STORE_DATA_O),
        .out_valid_o (STORE_VALID_O),
        .out_ready_i (STORE_READY_I)
    );

    sequence s_rise;
        rise_evt;
    endsequence

    sequence s_fall_after_rise;
        rise_pending && fall_evt;
    endsequence

    property p_shift_in;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        s_rise |=> shift_stages[0] == $past(data_in)
                   && shift_stages[N-1:1] == $past(shift_stages[N-2:0]);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift step wrong");

    property p_fast_tap;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        s_rise |=> CASCADE_OUT_FAST_O == $past(shift_stages[6])
                   && CASCADE_OUT_FAST_O == shift_stages[7];
    endproperty
    a_fast_tap: assert property (p_fast_tap) else $error("fast cascade wrong");

    property p_fast_hold;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !rise_evt |=> $stable(CASCADE_OUT_FAST_O);
    endproperty
    a_fast_hold: assert property (p_fast_hold) else $error("fast cascade moved");

    property p_slow_tap;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        fall_evt |=> CASCADE_OUT_SLOW_O == $past(shift_stages[7]);
    endproperty
    a_slow_tap: assert property (p_slow_tap) else $error("slow cascade wrong");

    property p_slow_lags_fast;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        s_fall_after_rise |=> CASCADE_OUT_SLOW_O == CASCADE_OUT_FAST_O;
    endproperty
    a_slow_lags_fast: assert property (p_slow_lags_fast) else $error("slow not fast");

    property p_slow_hold;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !fall_evt |=> $stable(CASCADE_OUT_SLOW_O);
    endproperty
    a_slow_hold: assert property (p_slow_hold) else $error("slow cascade moved");

    property p_store_pass;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        strobe_lvl |=> PARALLEL_OUTPUTS_O == $past(shift_stages);
    endproperty
    a_store_pass: assert property (p_store_pass)
        else $error("storage missed shift data");

    property p_store_hold;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !strobe_lvl |=> $stable(PARALLEL_OUTPUTS_O);
    endproperty
    a_store_hold: assert property (p_store_hold)
        else $error("storage moved with strobe low");

    // judged from the synchroniser, so a broken filter or enable path is caught
    property p_oe_drive;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        sync2.output_enable && sync3.output_enable |=> PARALLEL_OE_O == ssr8_pkg::OE_ALL;
    endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("port not driven");

    property p_oe_release;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !sync2.output_enable && !sync3.output_enable |=> PARALLEL_OE_O == ssr8_pkg::OE_NONE;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("port driven with oe low");

    property p_oe_no_effect;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (oe_lvl != next_filt.output_enable) && !rise_evt |=> $stable(shift_stages);
    endproperty
    a_oe_no_effect: assert property (p_oe_no_effect) else $error("oe changed stages");

    property p_cascade_oe_free;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        s_rise ##0 !oe_lvl |=> CASCADE_OUT_FAST_O == $past(shift_stages[6]);
    endproperty
    a_cascade_oe_free: assert property (p_cascade_oe_free)
        else $error("cascade gated by oe");
endmodule // ssr8_top

// ### ssr8_host_model.sv
/*
 * Host controller model: drives serial data, shift clock, store strobe, output enable.
 * Assumes one system clock; pins change on its falling edge, each level held hold cycles.
 */
`timescale 1ns/1ps
module ssr8_host_model (
    input  wire logic CLK_I,
    output logic      shift_clock_o,
    output logic      serial_data_o,
    output logic      store_strobe_o,
    output logic      output_enable_o
);
    // idle pins; the shift clock stands low outside frames
    initial begin
        shift_clock_o   = 1'b0;
        serial_data_o   = 1'b0;
        store_strobe_o  = 1'b0;
        output_enable_o = 1'b1;
    end

    // one bit: data set up, clock raised, then the data line is no longer held
    task automatic put_bit(input logic d, input int hold);
        @(negedge CLK_I);
        serial_data_o = d;
        repeat (hold) @(negedge CLK_I);
        shift_clock_o = 1'b1;
        repeat (hold) @(negedge CLK_I);
        serial_data_o = ~d; // hold over, so a stale bit cannot pass for a good one
    endtask

    // clock low again; the strobe stays low while shifting to avoid ripple
    task automatic drop_clock(input int hold);
        @(negedge CLK_I);
        shift_clock_o = 1'b0;
        repeat (hold) @(negedge CLK_I);
    endtask

    // publish the byte once all eight bits are in
    task automatic pulse_strobe(input int hold);
        @(negedge CLK_I);
        store_strobe_o = 1'b1;
        repeat (hold) @(negedge CLK_I);
        store_strobe_o = 1'b0;
        repeat (hold) @(negedge CLK_I);
    endtask

    task automatic set_enable(input logic en);
        @(negedge CLK_I);
        output_enable_o = en;
    endtask
endmodule // ssr8_host_model

// ### ssr8_testbench.sv
/*
 * Self-checking testbench for ssr8_top driven by the host controller model.
 * Assumes outputs settle within six CLK_I periods after any pin change.
 */
`timescale 1ns/1ps
module testbench;
    logic       clk_i;
    logic       sys_rst_i;
    logic       store_ready_i;
    wire logic  shift_clock, serial_data, store_strobe, output_enable;
    logic [7:0] parallel_outputs, parallel_oe, store_data;
    logic       cascade_fast, cascade_slow, store_valid, store_room;
    logic [7:0] exp_stage, exp_store;
    logic       exp_slow;
    logic [7:0] exp_q[$];
    int         err_count;
    int         num_checks;

    ssr8_host_model host_u (.CLK_I(clk_i), .shift_clock_o(shift_clock),
        .serial_data_o(serial_data), .store_strobe_o(store_strobe),
        .output_enable_o(output_enable));

    ssr8_top dut_u (.CLK_I(clk_i), .SYS_RST_I(sys_rst_i), .SHIFT_CLOCK_I(shift_clock),
        .SERIAL_DATA_I(serial_data), .STORE_STROBE_I(store_strobe),
        .OUTPUT_ENABLE_I(output_enable), .PARALLEL_OUTPUTS_O(parallel_outputs),
        .PARALLEL_OE_O(parallel_oe), .CASCADE_OUT_FAST_O(cascade_fast),
        .CASCADE_OUT_SLOW_O(cascade_slow), .STORE_DATA_O(store_data),
        .STORE_VALID_O(store_valid), .STORE_READY_I(store_ready_i),
        .STORE_ROOM_O(store_room));

    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // one bit in, cascades judged after the rise and after the fall
    task automatic shift_bit(input logic d, input int hold);
        host_u.put_bit(d, hold);
        exp_stage = {exp_stage[6:0], d};
        wait_clk(3);
        chk1(cascade_fast, exp_stage[7]);
        chk1(cascade_slow, exp_slow);
        chk8(parallel_outputs, exp_store);
        host_u.drop_clock(hold);
        wait_clk(3);
        exp_slow = exp_stage[7];
        chk1(cascade_slow, exp_slow);
        chk1(cascade_fast, exp_stage[7]);
    endtask

    task automatic send_byte(input logic [7:0] b, input int hold);
        for (int i = 7; i >= 0; i--) begin
            shift_bit(b[i], hold);
        end
    endtask

    // strobe pulse; a full buffer drops the byte
    task automatic publish(input int hold);
        host_u.pulse_strobe(hold);
        wait_clk(3);
        exp_store = exp_stage;
        if (exp_q.size() < 2) begin
            exp_q.push_back(exp_stage);
        end
        chk8(parallel_outputs, exp_store);
    endtask

    task automatic t_reset();
        chk8(parallel_oe, ssr8_pkg::OE_NONE);
        chk1(store_valid, 1'b0);
        chk1(store_room, 1'b1);
        chk1(cascade_fast, ssr8_pkg::CASCADE_RST);
        $display("test reset done");
    endtask

    task automatic t_basic();
        send_byte(8'hA5, 3);
        publish(3);
        chk8(parallel_oe, ssr8_pkg::OE_ALL);
        chk1(store_valid, 1'b1);
        chk8(store_data, 8'hA5);
        $display("test basic done");
    endtask

    // slow host, port disabled while a new byte goes in
    task automatic t_enable();
        host_u.set_enable(1'b0);
        wait_clk(6);
        chk8(parallel_oe, ssr8_pkg::OE_NONE);
        chk8(parallel_outputs, exp_store);
        send_byte(8'h3C, 8);
        publish(8);
        chk8(parallel_oe, ssr8_pkg::OE_NONE);
        chk1(store_room, 1'b0);
        host_u.set_enable(1'b1);
        wait_clk(6);
        chk8(parallel_oe, ssr8_pkg::OE_ALL);
        chk8(parallel_outputs, exp_store);
        $display("test enable done");
    endtask

    // third byte refused while the consumer stalls, then drained in order
    task automatic t_buffer();
        send_byte(8'h81, 3);
        publish(3);
        while (exp_q.size() > 0) begin
            chk1(store_valid, 1'b1);
            chk8(store_data, exp_q.pop_front());
            store_ready_i = 1'b1;
            wait_clk(1);
            store_ready_i = 1'b0;
            wait_clk(1);
        end
        chk1(store_valid, 1'b0);
        chk1(store_room, 1'b1);
        $display("test buffer done");
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // the tests need about 600 cycles; about eight times that means a hang
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        stop_test();
    end

    initial begin
        store_ready_i = 1'b0;
        sys_rst_i = 1'b1;
        exp_stage = 8'h00;
        exp_store = 8'h00;
        exp_slow = 1'b0;
        err_count = 0;
        num_checks = 0;
        wait_clk(10);
        sys_rst_i = 1'b0;
        wait_clk(1);
        t_reset();
        t_basic();
        t_enable();
        t_buffer();
        stop_test();
    end
endmodule // testbench
